// File: fdoc_params.svh
`ifndef FDOC_PARAMS_SVH
`define FDOC_PARAMS_SVH
// Register byte offsets on the bus.
`define FDOC_OFF_DECODE   12'h000
`define FDOC_OFF_RESULT   12'h004
`define FDOC_OFF_FLAGS_WR 12'h008
`define FDOC_OFF_FLAGS    12'h00c
`define FDOC_OFF_QUERY    12'h010
`define FDOC_OFF_FEAT_D   12'h014
`define FDOC_OFF_SIG_A    12'h018
`define FDOC_OFF_IRQ_STAT 12'h01c
`define FDOC_OFF_IRQ_MASK 12'h020
`define FDOC_OFF_VCSR     12'h024
// Feature word bit positions.
`define FDOC_FD_FPU      0
`define FDOC_FD_TSC      4
`define FDOC_FD_MSR      5
`define FDOC_FD_CX8      8
`define FDOC_FD_CMOV     15
// Flags register bit positions.
`define FDOC_FL_AC       18
`define FDOC_FL_VIF      19
`define FDOC_FL_VIP      20
`define FDOC_FL_ID       21
// Family field of the signature word, and the family that brings new opcodes.
`define FDOC_SIG_FAM_LO  8
`define FDOC_SIG_FAM_HI  11
`define FDOC_FAMILY_NEW  4'h6
// Interrupt status bit positions.
`define FDOC_IRQ_OPCODE  0
`define FDOC_IRQ_TESTREG 1
`define FDOC_IRQ_FLAGRSV 2
// Reset values.
`define FDOC_RST_FLAGS   32'h0000_0002
`define FDOC_RST_VCSR    32'h0000_1f80
`endif

// File: fdoc_pkg.sv
package fdoc_pkg;
  // Instruction classes that decode recognises.
  typedef enum logic [3:0] {
    FDOC_OP_PLAIN, FDOC_OP_CMOV, FDOC_OP_FCMOV, FDOC_OP_FLOAT_COMPARE_SET_FLAGS, FDOC_OP_READ_PERF_COUNTER_INSTR,
    FDOC_OP_UD2, FDOC_OP_CX8, FDOC_OP_QUERY, FDOC_OP_READ_TIMESTAMP_INSTR, FDOC_OP_READ_MODEL_REG_INSTR,
    FDOC_OP_WRITE_MODEL_REG_INSTR, FDOC_OP_TESTREG_RD, FDOC_OP_TESTREG_WR, FDOC_OP_RESERVED
  } fdoc_op_e;
  // Bus transfer phase.
  typedef enum logic [1:0] {FDOC_IDLE, FDOC_WRITE, FDOC_READ} fdoc_phase_e;
endpackage : fdoc_pkg

// File: fdoc_core.sv
`include "fdoc_params.svh"
`timescale 1ns/10ps
`default_nettype none
module fdoc_core #(
  parameter bit         HAS_FPU    = 1'b1,
  parameter bit         HAS_CMOV   = 1'b1,
  parameter bit         HAS_CX8    = 1'b1,
  parameter bit         HAS_TSC    = 1'b1,
  parameter bit         HAS_MSR    = 1'b1,
  parameter bit         HAS_QUERY  = 1'b1,
  parameter bit         HAS_AC     = 1'b1,
  parameter bit         HAS_VME    = 1'b1,
  parameter bit         HAS_VEC    = 1'b1,
  parameter logic [3:0] FAMILY     = 4'h6,
  parameter logic [3:0] MODEL_ID   = 4'h1,  // Arbitrary value.
  parameter logic [3:0] STEPPING   = 4'h0   // Arbitrary value.
) (
  // Clock and reset.
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  // AHB-Lite slave.
  input  wire logic        hsel,
  input  wire logic [11:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Fault and interrupt.
  output logic             invalid_opcode_fault,
  output logic             flag_exception,
  output logic             irq
);

  // Feature words fixed at build time, consistent with decode below.
  // Both follow the same parameters, so the query and the decoder cannot disagree.
  logic [31:0] feature_word_d;
  logic [31:0] signature_word_a;
  logic        new_family;
  always_comb
  begin
    feature_word_d = 32'h0;
    feature_word_d[`FDOC_FD_FPU]  = HAS_FPU;
    feature_word_d[`FDOC_FD_CMOV] = HAS_CMOV;
    feature_word_d[`FDOC_FD_CX8]  = HAS_CX8;
    feature_word_d[`FDOC_FD_TSC]  = HAS_TSC;
    feature_word_d[`FDOC_FD_MSR]  = HAS_MSR;
    signature_word_a = {20'h0, FAMILY, MODEL_ID, STEPPING};
  end
  assign new_family = (FAMILY >= `FDOC_FAMILY_NEW);

  // Bus address phase capture.
  // The address is taken on every ready cycle; only the phase flags gate any effect.
  logic                 wr_ph_ff, rd_ph_ff;
  logic [11:0]          addr_ff;
  wire                  take = hsel & hready & htrans[1];
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wr_ph_ff <= 1'b0;
      rd_ph_ff <= 1'b0;
      addr_ff  <= 12'h0;
    end
    else if (hready)
    begin
      wr_ph_ff <= take & hwrite;
      rd_ph_ff <= take & ~hwrite;
      addr_ff  <= haddr;
    end
  end

  wire w_decode  = wr_ph_ff && (addr_ff == `FDOC_OFF_DECODE);
  wire w_flagswr = wr_ph_ff && (addr_ff == `FDOC_OFF_FLAGS_WR);
  wire w_stat    = wr_ph_ff && (addr_ff == `FDOC_OFF_IRQ_STAT);
  wire w_mask    = wr_ph_ff && (addr_ff == `FDOC_OFF_IRQ_MASK);
  wire w_vcsr    = wr_ph_ff && (addr_ff == `FDOC_OFF_VCSR);

  // Decode check: the written word's low nibble selects the instruction class.
  // Codes past the last class fall to the default arm and fault, so spare codes stay safe.
  fdoc_pkg::fdoc_op_e op;
  logic               op_ok, op_fault, tr_fault;
  assign op = fdoc_pkg::fdoc_op_e'(hwdata[3:0]);
  always_comb
  begin
    op_ok = 1'b0;
    case (op)
      fdoc_pkg::FDOC_OP_PLAIN:  op_ok = 1'b1;
      fdoc_pkg::FDOC_OP_CMOV:   op_ok = HAS_CMOV;
      fdoc_pkg::FDOC_OP_FCMOV,
      fdoc_pkg::FDOC_OP_FLOAT_COMPARE_SET_FLAGS:  op_ok = HAS_CMOV & HAS_FPU;
      fdoc_pkg::FDOC_OP_READ_PERF_COUNTER_INSTR,
      fdoc_pkg::FDOC_OP_UD2:    op_ok = new_family;
      fdoc_pkg::FDOC_OP_CX8:    op_ok = HAS_CX8;
      fdoc_pkg::FDOC_OP_QUERY:  op_ok = HAS_QUERY;
      fdoc_pkg::FDOC_OP_READ_TIMESTAMP_INSTR:  op_ok = HAS_TSC;
      fdoc_pkg::FDOC_OP_READ_MODEL_REG_INSTR,
      fdoc_pkg::FDOC_OP_WRITE_MODEL_REG_INSTR:  op_ok = HAS_MSR;
      default:                  op_ok = 1'b0;
    endcase
  end
  // Test-register moves and reserved codes never execute.
  assign tr_fault = (op == fdoc_pkg::FDOC_OP_TESTREG_RD) ||
                    (op == fdoc_pkg::FDOC_OP_TESTREG_WR);
  assign op_fault = w_decode & (~op_ok | tr_fault);

  // Writable flag positions: unimplemented ones are reserved.
  // Bit 1 is not writable: it is forced to one on every store, so writing it is a reserved touch.
  logic [31:0] flag_impl;
  always_comb
  begin
    flag_impl = 32'h0000_7fd5;
    flag_impl[`FDOC_FL_AC]  = HAS_AC;
    flag_impl[`FDOC_FL_VIF] = HAS_VME;
    flag_impl[`FDOC_FL_VIP] = HAS_VME;
    flag_impl[`FDOC_FL_ID]  = HAS_QUERY;
  end
  wire rsv_touch = w_flagswr & |(hwdata & ~flag_impl);
  wire [31:0] nxt_flags = (hwdata & flag_impl) | `FDOC_RST_FLAGS;

  // Flags, faults, vector control word and interrupt state.
  // Status takes an event over a clear in the same cycle, so no event is ever lost.
  // The interrupt uses the mask being written, so unmasking shows on the line at once.
  logic [31:0] flags_register_ff, vector_ctrl_status_ff, result_ff;
  logic [2:0]  irq_stat_ff, irq_mask_ff;
  wire  [2:0]  ev = {rsv_touch, w_decode & tr_fault, op_fault};
  wire  [2:0]  nxt_stat = (irq_stat_ff & ~(w_stat ? hwdata[2:0] : 3'h0)) | ev;
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      flags_register_ff     <= `FDOC_RST_FLAGS;
      vector_ctrl_status_ff <= `FDOC_RST_VCSR;
      result_ff             <= 32'h0;
      irq_stat_ff           <= 3'h0;
      irq_mask_ff           <= 3'h0;
      invalid_opcode_fault  <= 1'b0;
      flag_exception        <= 1'b0;
      irq                   <= 1'b0;
    end
    else
    begin
      if (w_flagswr)
        flags_register_ff <= nxt_flags;
      if (w_vcsr && HAS_VEC)
        vector_ctrl_status_ff <= hwdata;
      if (w_decode)
        result_ff <= (op_ok & ~tr_fault) ? 32'h1 : 32'h0;
      if (w_mask)
        irq_mask_ff <= hwdata[2:0];
      irq_stat_ff          <= nxt_stat;
      invalid_opcode_fault <= op_fault;
      flag_exception       <= rsv_touch;
      irq                  <= |(nxt_stat & (w_mask ? hwdata[2:0] : irq_mask_ff));
    end
  end

  // Eight 128-bit vector registers, reachable only by their own unit.
  // No bus path loads them, and no logic in this block writes them after the reset clear.
  logic [127:0] vector_regs [8];
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_vreg
      always_ff @(posedge mclk or posedge sys_rst)
      begin
        if (sys_rst)
          vector_regs[gi] <= 128'h0;
      end
    end
  endgenerate

  // Read data selection; unmapped offsets read zero so probing software sees no stray bits.
  logic [31:0] rmux;
  always_comb
  begin
    rmux = 32'h0;
    if (haddr == `FDOC_OFF_RESULT)
      rmux = result_ff;
    else if (haddr == `FDOC_OFF_FLAGS)
      rmux = flags_register_ff;
    else if (haddr == `FDOC_OFF_QUERY)
      rmux = {31'h0, HAS_QUERY};
    else if (haddr == `FDOC_OFF_FEAT_D)
      rmux = HAS_QUERY ? feature_word_d : 32'h0;
    else if (haddr == `FDOC_OFF_SIG_A)
      rmux = HAS_QUERY ? signature_word_a : 32'h0;
    else if (haddr == `FDOC_OFF_IRQ_STAT)
      rmux = {29'h0, irq_stat_ff};
    else if (haddr == `FDOC_OFF_IRQ_MASK)
      rmux = {29'h0, irq_mask_ff};
    else if (haddr == `FDOC_OFF_VCSR)
      rmux = HAS_VEC ? vector_ctrl_status_ff : 32'h0;
  end
  // This slave never stalls and never errors, so ready and response stay at reset values.
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      hrdata    <= 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else if (take & ~hwrite)
      hrdata <= rmux;
  end

  // Guards.
  a_resv_fault: assert property (@(posedge mclk) disable iff (sys_rst)
    (w_decode && op == fdoc_pkg::FDOC_OP_RESERVED) |=> invalid_opcode_fault)
    else $error("reserved opcode did not fault");
  a_treg_fault: assert property (@(posedge mclk) disable iff (sys_rst)
    (w_decode && tr_fault) |=> invalid_opcode_fault && irq_stat_ff[1])
    else $error("test register move did not fault");
  a_flag_exc: assert property (@(posedge mclk) disable iff (sys_rst)
    (w_flagswr && |(hwdata & ~flag_impl)) |=> flag_exception)
    else $error("reserved flag touch missed");
  a_feat_bits: assert property (@(posedge mclk) disable iff (sys_rst)
    feature_word_d[15] == HAS_CMOV && feature_word_d[8] == HAS_CX8)
    else $error("feature word wrong");
  a_feat_tsc: assert property (@(posedge mclk) disable iff (sys_rst)
    feature_word_d[4] == HAS_TSC && feature_word_d[5] == HAS_MSR)
    else $error("timestamp or model bit wrong");
  a_id_toggle: assert property (@(posedge mclk) disable iff (sys_rst)
    (w_flagswr && HAS_QUERY) |=> flags_register_ff[21] == $past(hwdata[21]))
    else $error("id flag not writable");
  a_vif_hold: assert property (@(posedge mclk) disable iff (sys_rst)
    !HAS_VME |-> flags_register_ff[20:19] == 2'b00)
    else $error("virtual flags set without support");
  a_irq_level: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(irq_stat_ff[0]) && irq_mask_ff[0] && $stable(irq_mask_ff) |-> irq)
    else $error("interrupt missing");

  // Bus and read path guards.
  a_bus_okay: assert property (@(posedge mclk) disable iff (sys_rst)
    hreadyout && !hresp)
    else $error("slave left zero-wait OKAY");
  a_read_data: assert property (@(posedge mclk) disable iff (sys_rst)
    rd_ph_ff |-> hrdata == $past(rmux))
    else $error("read data not from address phase");

  // Decode guards: each feature-gated fault follows the built feature or signature word, or HAS_QUERY for the query opcode.
  a_stat_opcode: assert property (@(posedge mclk) disable iff (sys_rst)
    op_fault |=> irq_stat_ff[`FDOC_IRQ_OPCODE])
    else $error("opcode fault not recorded");
  a_no_exec: assert property (@(posedge mclk) disable iff (sys_rst)
    (w_decode && !op_ok) |=> result_ff == 32'h0)
    else $error("unsupported opcode executed");
  a_cmov_match: assert property (@(posedge mclk) disable iff (sys_rst)
    (w_decode && op == fdoc_pkg::FDOC_OP_CMOV) |=>
    invalid_opcode_fault == !feature_word_d[`FDOC_FD_CMOV])
    else $error("conditional move disagrees with feature word");
  a_fcmov_match: assert property (@(posedge mclk) disable iff (sys_rst)
    (w_decode && (op == fdoc_pkg::FDOC_OP_FCMOV || op == fdoc_pkg::FDOC_OP_FLOAT_COMPARE_SET_FLAGS)) |=>
    invalid_opcode_fault == !(feature_word_d[`FDOC_FD_FPU] && feature_word_d[`FDOC_FD_CMOV]))
    else $error("float conditional forms disagree with feature word");
  a_cx8_match: assert property (@(posedge mclk) disable iff (sys_rst)
    (w_decode && op == fdoc_pkg::FDOC_OP_CX8) |=>
    invalid_opcode_fault == !feature_word_d[`FDOC_FD_CX8])
    else $error("eight-byte exchange disagrees with feature word");
  a_tsc_match: assert property (@(posedge mclk) disable iff (sys_rst)
    (w_decode && op == fdoc_pkg::FDOC_OP_READ_TIMESTAMP_INSTR) |=>
    invalid_opcode_fault == !feature_word_d[`FDOC_FD_TSC])
    else $error("timestamp read disagrees with feature word");
  a_msr_match: assert property (@(posedge mclk) disable iff (sys_rst)
    (w_decode && (op == fdoc_pkg::FDOC_OP_READ_MODEL_REG_INSTR || op == fdoc_pkg::FDOC_OP_WRITE_MODEL_REG_INSTR)) |=>
    invalid_opcode_fault == !feature_word_d[`FDOC_FD_MSR])
    else $error("model register access disagrees with feature word");
  a_family_gate: assert property (@(posedge mclk) disable iff (sys_rst)
    (w_decode && (op == fdoc_pkg::FDOC_OP_READ_PERF_COUNTER_INSTR || op == fdoc_pkg::FDOC_OP_UD2)) |=>
    invalid_opcode_fault ==
      (signature_word_a[`FDOC_SIG_FAM_HI:`FDOC_SIG_FAM_LO] < `FDOC_FAMILY_NEW))
    else $error("family gated opcode disagrees with signature");
  a_query_bit: assert property (@(posedge mclk) disable iff (sys_rst)
    (w_decode && op == fdoc_pkg::FDOC_OP_QUERY) |=> invalid_opcode_fault == !HAS_QUERY)
    else $error("feature query decode disagrees with build");

  // Flag and vector control guards.
  a_ac_hold: assert property (@(posedge mclk) disable iff (sys_rst)
    !HAS_AC |-> !flags_register_ff[`FDOC_FL_AC])
    else $error("alignment check set without support");
  a_ac_store: assert property (@(posedge mclk) disable iff (sys_rst)
    (w_flagswr && HAS_AC) |=>
    flags_register_ff[`FDOC_FL_AC] == $past(hwdata[`FDOC_FL_AC]))
    else $error("alignment check not stored");
  a_vif_store: assert property (@(posedge mclk) disable iff (sys_rst)
    (w_flagswr && HAS_VME) |=>
    flags_register_ff[`FDOC_FL_VIP:`FDOC_FL_VIF] == $past(hwdata[`FDOC_FL_VIP:`FDOC_FL_VIF]))
    else $error("virtual interrupt flags not stored");
  a_fixed_one: assert property (@(posedge mclk) disable iff (sys_rst)
    flags_register_ff[1])
    else $error("fixed flag bit lost");
  a_vec_hold: assert property (@(posedge mclk) disable iff (sys_rst)
    !HAS_VEC |-> vector_ctrl_status_ff == `FDOC_RST_VCSR)
    else $error("vector control changed without support");
endmodule : fdoc_core
`default_nettype wire

// File: feature_detect_opcode_check_tb.sv
`include "fdoc_params.svh"
`timescale 1ns/10ps
`default_nettype none
module feature_detect_opcode_check_tb;
  logic        mclk;
  logic        sys_rst;
  logic        hsel;
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        invalid_opcode_fault;
  logic        flag_exception;
  logic        irq;
  logic [31:0] rd;
  logic [31:0] v;
  integer      seed;
  int          mismatches;
  int          comparisons;

  // The single slave's hreadyout is fed back as the bus hready.
  fdoc_core i_dut (.mclk(mclk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .invalid_opcode_fault(invalid_opcode_fault), .flag_exception(flag_exception), .irq(irq));

  // Free-running 40 MHz clock.
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // Compare tasks, one per kind of result.
  task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk32

  task automatic chk1(input string nm, input logic e, input logic g);
    chk32(nm, {31'h0, e}, {31'h0, g});
  endtask : chk1

  // Single AHB-Lite word transfer; waits on hready rather than assuming zero wait states.
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= w;
    hsize  <= 3'b010;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1)
      mismatches++;
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1)
      mismatches++;
    rd = hrdata;
  endtask : bus

  // The signal must match the expected level for the one cycle after the data phase and then be low.
  task automatic pulse(input string nm, input logic e, ref logic sig);
    #1 chk1(nm, e, sig);
    @(posedge mclk);
    #1 chk1(nm, 1'b0, sig);
  endtask : pulse

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : close_out

  // Watchdog well beyond the few hundred cycles the sequence needs.
  initial
  begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    close_out();
  end

  // Main sequence.
  initial
  begin
    seed = 32'h89a9;
    mismatches = 0;
    comparisons = 0;
    sys_rst = 1'b1; hsel = 1'b0; haddr = 12'h000; htrans = 2'b00;
    hwrite = 1'b0; hsize = 3'b010; hwdata = 32'h0;
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    bus(1'b0, `FDOC_OFF_FLAGS, 32'h0); chk32("flags_rst", `FDOC_RST_FLAGS, rd);
    bus(1'b0, `FDOC_OFF_VCSR, 32'h0); chk32("vcsr_rst", `FDOC_RST_VCSR, rd);
    bus(1'b0, `FDOC_OFF_IRQ_STAT, 32'h0); chk32("irq_stat_rst", 32'h0, rd);
    bus(1'b0, 12'h100, 32'h0); chk32("unmapped", 32'h0, rd);
    chk1("hresp", 1'b0, hresp);
    chk1("hreadyout", 1'b1, hreadyout);
    $display("test reset_and_map done");
    // Feature and signature words.
    bus(1'b0, `FDOC_OFF_FEAT_D, 32'h0); chk32("feat_d", 32'h0000_8131, rd);
    bus(1'b0, `FDOC_OFF_QUERY, 32'h0);
    chk32("query", 32'h1, rd);
    bus(1'b0, `FDOC_OFF_SIG_A, 32'h0); chk32("family", 32'h6, (rd >> 8) & 32'hf);
    $display("test query done");
    // Every instruction class including the reserved codes above the enum.
    for (int op = 0; op < 16; op++)
    begin
      bus(1'b1, `FDOC_OFF_DECODE, op);
      pulse("opcode_fault", op >= 11, invalid_opcode_fault);
      bus(1'b0, `FDOC_OFF_RESULT, 32'h0); chk32("result", {31'h0, op < 11}, rd);
    end
    bus(1'b0, `FDOC_OFF_IRQ_STAT, 32'h0); chk32("stat_op", 32'h3, rd & 32'h3);
    $display("test decode done");
    // Query flag must toggle both ways, then random implemented-bit patterns.
    for (int i = 0; i < 6; i++)
    begin
      v = (i == 0) ? 32'h0020_0000 : (i == 1) ? 32'h0 : ($random(seed) & 32'h003c_7fd5);
      bus(1'b1, `FDOC_OFF_FLAGS_WR, v);
      pulse("flag_exc", 1'b0, flag_exception);
      bus(1'b0, `FDOC_OFF_FLAGS, 32'h0); chk32("flags", v | 32'h2, rd);
    end
    // Touching an unimplemented flag raises the exception.
    bus(1'b1, `FDOC_OFF_FLAGS_WR, 32'h0040_0000);
    pulse("flag_exc", 1'b1, flag_exception);
    bus(1'b0, `FDOC_OFF_IRQ_STAT, 32'h0); chk32("stat_flag", 32'h4, rd & 32'h4);
    $display("test flags done");
    // Vector control word takes a random whole word.
    v = $random(seed);
    bus(1'b1, `FDOC_OFF_VCSR, v);
    bus(1'b0, `FDOC_OFF_VCSR, 32'h0);
    chk32("vcsr", v, rd);
    $display("test vector control done");
    // Interrupt: masked off, unmasked, then cleared by writing ones.
    #1 chk1("irq_masked", 1'b0, irq);
    bus(1'b1, `FDOC_OFF_IRQ_MASK, 32'h7);
    @(posedge mclk); #1 chk1("irq_on", 1'b1, irq);
    bus(1'b1, `FDOC_OFF_IRQ_STAT, 32'h7);
    @(posedge mclk); #1 chk1("irq_off", 1'b0, irq);
    bus(1'b0, `FDOC_OFF_IRQ_STAT, 32'h0); chk32("stat_clr", 32'h0, rd & 32'h7);
    bus(1'b1, `FDOC_OFF_DECODE, 32'hf);
    pulse("opcode_fault", 1'b1, invalid_opcode_fault);
    chk1("irq_again", 1'b1, irq);
    bus(1'b1, `FDOC_OFF_IRQ_MASK, 32'h0);
    @(posedge mclk); #1 chk1("irq_mask0", 1'b0, irq);
    $display("test irq done");
    close_out();
  end
endmodule : feature_detect_opcode_check_tb
`default_nettype wire
